/* File: verilog/pmc_power_mode_controller.v */
// power mode sequencer: run, slow, wait, halt and stop clock gating
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.vh"
module pmc_power_mode_controller #(
    parameter STAB_CYCLES = `PMC_STAB_CYC,
    parameter [7:0] SLOW_DIV = `PMC_SLOW_DIV
) (
    input wire SYS_CLK,
    input wire ARST_N,
    input wire [2:0] MODE_REQ,
    input wire [1:0] CLK_SRC_SEL,
    input wire [7:0] WFI_DIV,
    input wire WDOG_ENABLE,
    input wire IRQ_ACK,
    input wire WAKEUP_LINE,
    output reg CPU_CLK_EN,
    output reg PERIPH_CLK_EN,
    output reg IRQ_CLK_EN,
    output reg [1:0] CLK_SRC,
    output reg OSC_RUN,
    output reg WDOG_FREEZE,
    output reg [2:0] MODE,
    output reg HALTED
);
    reg [2:0] state_r, state_nxt;
    reg [19:0] stab_cnt_r;
    reg [7:0] div_cnt_r;
    reg [2:0] wk_sync_r;
    reg wk_lvl_r;
    reg tick;
    reg [7:0] div_sel;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // source actually used; the spare code falls back to the pll
    function [1:0] src_map;
        input [1:0] code;
        begin
            if (code == `PMC_SRC_RSVD)
                src_map = `PMC_SRC_PLL;
            else
                src_map = code;
        end
    endfunction

    // watchdog held while the oscillator is off or not yet trusted
    function freeze_mode;
        input [2:0] st;
        begin
            freeze_mode = (st == `PMC_ST_STOP) || (st == `PMC_ST_STAB);
        end
    endfunction

    // ----------------------------------------------------------------
    // wake-up pin synchroniser
    // ----------------------------------------------------------------
    // three stages, a change counts once stages two and three agree
    // reset level matches the idle low pin, so no false wake after reset
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wk_sync_r <= 3'h0;
            wk_lvl_r <= 1'b0;
        end else begin
            wk_sync_r <= {wk_sync_r[1:0], WAKEUP_LINE};
            if (wk_sync_r[1] == wk_sync_r[2])
                wk_lvl_r <= wk_sync_r[2];
        end
    end

    // ----------------------------------------------------------------
    // mode state machine
    // ----------------------------------------------------------------
    // requests are taken only in run and slow; wait, stop and the
    // stabilisation wait each have one way out, and halt has none
    // next mode from request and events
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `PMC_ST_RUN, `PMC_ST_SLOW: begin
                if (MODE_REQ == `PMC_REQ_SLOW)
                    state_nxt = `PMC_ST_SLOW;
                else if (MODE_REQ == `PMC_REQ_RUN)
                    state_nxt = `PMC_ST_RUN;
                else if (MODE_REQ == `PMC_REQ_WFI)
                    state_nxt = `PMC_ST_WFI;
                else if (MODE_REQ == `PMC_REQ_HALT && !WDOG_ENABLE)
                    state_nxt = `PMC_ST_HALT;
                else if (MODE_REQ == `PMC_REQ_STOP)
                    state_nxt = `PMC_ST_STOP;
            end
            `PMC_ST_WFI: begin
                if (IRQ_ACK)
                    state_nxt = `PMC_ST_RUN;
            end
            `PMC_ST_HALT: begin
                state_nxt = `PMC_ST_HALT;
            end
            `PMC_ST_STOP: begin
                if (wk_lvl_r)
                    state_nxt = `PMC_ST_STAB;
            end
            `PMC_ST_STAB: begin
                if (stab_cnt_r == 20'h00000)
                    state_nxt = `PMC_ST_RUN;
            end
            default: state_nxt = `PMC_ST_RUN;
        endcase
    end

    // state register; halt has no exit above, so only reset leaves it
    // and every register restarts from its reset value
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N)
            state_r <= `PMC_ST_RUN;
        else
            state_r <= state_nxt;
    end

    // ----------------------------------------------------------------
    // oscillator stabilisation counter
    // ----------------------------------------------------------------
    // loaded on stop, counts down after wake-up
    // reloaded every stop cycle, so each wake-up waits the full time
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N)
            stab_cnt_r <= 20'h00000;
        else if (state_r == `PMC_ST_STOP)
            stab_cnt_r <= STAB_CYCLES[19:0] - 20'h00001;
        else if (state_r == `PMC_ST_STAB && stab_cnt_r != 20'h00000)
            stab_cnt_r <= stab_cnt_r - 20'h00001;
    end

    // ----------------------------------------------------------------
    // clock divider for slow and wait modes
    // ----------------------------------------------------------------
    // divisor chosen by mode; zero means undivided
    // the counter runs free, so a first pulse after a switch may be early
    always @* begin
        if (state_r == `PMC_ST_WFI)
            div_sel = WFI_DIV;
        else if (state_r == `PMC_ST_SLOW)
            div_sel = SLOW_DIV;
        else
            div_sel = `PMC_DIV_NONE;
        tick = (div_cnt_r >= div_sel);
    end

    // free divider counter
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N)
            div_cnt_r <= 8'h00;
        else if (tick)
            div_cnt_r <= 8'h00;
        else
            div_cnt_r <= div_cnt_r + 8'h01;
    end

    // ----------------------------------------------------------------
    // clock enable outputs
    // ----------------------------------------------------------------
    // gate enables registered from the current state, one edge behind it
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CPU_CLK_EN <= `PMC_RST_EN;
            PERIPH_CLK_EN <= `PMC_RST_EN;
            IRQ_CLK_EN <= `PMC_RST_EN;
            CLK_SRC <= `PMC_SRC_PLL;
            OSC_RUN <= `PMC_RST_OSC;
            WDOG_FREEZE <= `PMC_RST_FREEZE;
            MODE <= `PMC_ST_RUN;
            HALTED <= `PMC_RST_HALTED;
        end else begin
            MODE <= state_r;
            HALTED <= (state_r == `PMC_ST_HALT);
            // the pll sits outside this block: software keeps it inside the
            // crystal and system limits of the defs header, and this block
            // only routes the selected source
            CLK_SRC <= src_map(CLK_SRC_SEL);
            OSC_RUN <= (state_r != `PMC_ST_STOP);
            WDOG_FREEZE <= freeze_mode(state_r);
            case (state_r)
                `PMC_ST_RUN: begin
                    CPU_CLK_EN <= 1'b1;
                    PERIPH_CLK_EN <= 1'b1;
                    IRQ_CLK_EN <= 1'b1;
                end
                `PMC_ST_SLOW: begin
                    CPU_CLK_EN <= tick;
                    PERIPH_CLK_EN <= tick;
                    IRQ_CLK_EN <= tick;
                end
                `PMC_ST_WFI: begin
                    CPU_CLK_EN <= 1'b0;
                    PERIPH_CLK_EN <= tick;
                    IRQ_CLK_EN <= tick;
                end
                default: begin
                    // halt, stop and stabilisation: all gated, regs kept
                    CPU_CLK_EN <= 1'b0;
                    PERIPH_CLK_EN <= 1'b0;
                    IRQ_CLK_EN <= 1'b0;
                end
            endcase
        end
    end
endmodule // pmc_power_mode_controller
`default_nettype wire

/* File: verilog/pmc_defs.vh */
// power mode controller constants
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
// mode state codes
`define PMC_ST_RUN 3'h0
`define PMC_ST_SLOW 3'h1
`define PMC_ST_WFI 3'h2
`define PMC_ST_HALT 3'h3
`define PMC_ST_STOP 3'h4
`define PMC_ST_STAB 3'h5
// mode request codes
`define PMC_REQ_NONE 3'h0
`define PMC_REQ_RUN 3'h1
`define PMC_REQ_SLOW 3'h2
`define PMC_REQ_WFI 3'h3
`define PMC_REQ_HALT 3'h4
`define PMC_REQ_STOP 3'h5
// clock source select
`define PMC_SRC_PLL 2'h0
`define PMC_SRC_OSC 2'h1
`define PMC_SRC_EXT 2'h2
// spare source code, routed to the pll
`define PMC_SRC_RSVD 2'h3
// slow mode divisor: one enable in five cycles
`define PMC_SLOW_DIV 8'h04
// divisor used outside slow and wait: every cycle enabled
`define PMC_DIV_NONE 8'h00
// output reset values
`define PMC_RST_EN 1'b1
`define PMC_RST_OSC 1'b1
`define PMC_RST_FREEZE 1'b0
`define PMC_RST_HALTED 1'b0
// pll limits in kHz
`define PMC_XTAL_MIN_KHZ 3000
`define PMC_XTAL_MAX_KHZ 5000
`define PMC_SYS_MAX_KHZ 25000
// oscillator stabilisation time in ns and cycles at 4 ns
`define PMC_STAB_NS 1000000
`define PMC_CLK_NS 4
`define PMC_STAB_CYC ((`PMC_STAB_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`endif

/* File: verification/pmc_core_model.sv */
// core-side partner: acknowledges interrupts and raises wake-up
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
    input wire logic clk,
    input wire logic [2:0] mode,
    input wire logic [3:0] dly,
    output logic irq_ack = 1'b0,
    output logic wake = 1'b0
);
    logic [3:0] cnt = 4'h0;
    // wait dly cycles in wait or stop mode, then answer
    always @(posedge clk) begin
        cnt <= (mode == 3'h2 || mode == 3'h4) ? cnt + 4'h1 : 4'h0;
        irq_ack <= #1 mode == 3'h2 && cnt >= dly;
        wake <= #1 mode == 3'h4 && cnt >= dly;
    end
endmodule // pmc_core_model
`default_nettype wire

/* File: verification/pmc_power_mode_controller_sva.sv */
// mode sequencing checks on the controller ports
`timescale 1ns/1ps
`default_nettype none
module pmc_sva (
    input wire SYS_CLK,
    input wire ARST_N,
    input wire [2:0] MODE_REQ,
    input wire WDOG_ENABLE,
    input wire IRQ_ACK,
    input wire CPU_CLK_EN,
    input wire PERIPH_CLK_EN,
    input wire OSC_RUN,
    input wire WDOG_FREEZE,
    input wire [2:0] MODE,
    input wire HALTED
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    // ----------------
    // assertions
    // ----------------
    halt_refuse_a: assert property (MODE < 3'h2 && MODE_REQ == 3'h4 &&
        $past(MODE_REQ) == 3'h0 && WDOG_ENABLE |-> ##2 !HALTED)
        else $error("halt taken with watchdog on");
    halt_entry_a: assert property (MODE < 3'h2 && MODE_REQ == 3'h4 &&
        $past(MODE_REQ) == 3'h0 && !WDOG_ENABLE |-> ##2
        HALTED && !CPU_CLK_EN && !PERIPH_CLK_EN)
        else $error("halt not entered");
    halt_stuck_a: assert property (HALTED |=> HALTED)
        else $error("halt left without reset");
    stop_gate_a: assert property (MODE == 3'h4 |-> !CPU_CLK_EN &&
        !PERIPH_CLK_EN && !OSC_RUN && WDOG_FREEZE)
        else $error("stop gating wrong");
    stab_hold_a: assert property (MODE == 3'h5 |->
        !CPU_CLK_EN && WDOG_FREEZE) else $error("ran before stable");
    wfi_gate_a: assert property (MODE == 3'h2 |-> !CPU_CLK_EN)
        else $error("cpu clocked in wait");
    wfi_wake_a: assert property (MODE == 3'h2 && IRQ_ACK |->
        ##2 MODE == 3'h0) else $error("no resume after ack");
    stop_resume_a: assert property ($fell(MODE == 3'h5) |->
        MODE == 3'h0 && CPU_CLK_EN && !WDOG_FREEZE)
        else $error("stop exit not to run");
    run_clock_a: assert property (MODE == 3'h0 |->
        CPU_CLK_EN && PERIPH_CLK_EN) else $error("run clocks gated");
endmodule // pmc_sva
bind pmc_power_mode_controller pmc_sva u_sva (.SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N), .MODE_REQ(MODE_REQ), .WDOG_ENABLE(WDOG_ENABLE),
    .IRQ_ACK(IRQ_ACK), .CPU_CLK_EN(CPU_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .OSC_RUN(OSC_RUN),
    .WDOG_FREEZE(WDOG_FREEZE), .MODE(MODE), .HALTED(HALTED));
`default_nettype wire

/* File: verification/test_power_mode_controller.sv */
// bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_controller;
    logic clk = 1'b0, rst_n = 1'b0, wdog = 1'b0;
    logic [2:0] req = 3'h0;
    logic [1:0] sel = 2'h0;
    logic [3:0] dly = 4'h1;
    logic [7:0] wdiv = 8'h03;
    wire cpu, per, irq, osc, frz, halted, ack, wake;
    wire [1:0] src;
    wire [2:0] mode;
    int error_cnt = 0, comparisons = 0, cyc = 0, n;
    pmc_power_mode_controller #(.STAB_CYCLES(8)) dut (.SYS_CLK(clk),
        .ARST_N(rst_n), .MODE_REQ(req), .CLK_SRC_SEL(sel), .WFI_DIV(wdiv),
        .WDOG_ENABLE(wdog), .IRQ_ACK(ack), .WAKEUP_LINE(wake),
        .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(per), .IRQ_CLK_EN(irq),
        .CLK_SRC(src), .OSC_RUN(osc), .WDOG_FREEZE(frz), .MODE(mode),
        .HALTED(halted));
    pmc_core_model core (.clk(clk), .mode(mode), .dly(dly), .irq_ack(ack),
        .wake(wake));
    always #2 clk = ~clk;
    // ----------------
    // helpers
    // ----------------
    task automatic test_done;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic cy(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rq(input logic [2:0] c);
        req = c;
        cy(1);
        req = 3'h0;
    endtask
    task automatic w(input logic [2:0] v);
        for (int i = 0; i < 40 && mode !== v; i++) cy(1);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_run;
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            cy(3);
            chk(src === ((s == 3) ? 2'h0 : sel) && cpu === 1'b1 &&
                irq === 1'b1 && mode === 3'h0, "run");
        end
        sel = 2'h1;
    endtask
    task automatic t_slow;
        rq(3'h2);
        cy(2);
        n = 0;
        repeat (10) begin
            n += (cpu === 1'b1);
            cy(1);
        end
        chk(mode === 3'h1 && n == 2, "slow rate");
        rq(3'h1);
        cy(2);
    endtask
    task automatic t_wfi;
        int m;
        dly = 4'hC;
        wdiv = 8'h01;
        rq(3'h3);
        cy(2);
        chk(mode === 3'h2 && cpu === 1'b0, "wait gating");
        n = 0;
        m = 0;
        repeat (8) begin
            chk(cpu === 1'b0 && mode === 3'h2, "wait cpu clock");
            n += (irq === 1'b1);
            m += (per === 1'b1);
            cy(1);
        end
        chk(n == 4 && m == 4, "wait clock rate");
        w(3'h0);
        chk(mode === 3'h0 && cpu === 1'b1, "wait resume");
    endtask
    task automatic t_stop;
        wdog = 1'b1;
        rq(3'h4);
        cy(3);
        chk(halted === 1'b0 && mode === 3'h0, "halt refused");
        dly = 4'h2;
        rq(3'h5);
        cy(2);
        chk(mode === 3'h4 && per === 1'b0 && frz && !osc, "stop");
        w(3'h5);
        for (n = 0; mode === 3'h5 && n < 40; n++) cy(1);
        chk(n == 8, "stabilise length");
        chk(mode === 3'h0 && frz === 1'b0 && osc === 1'b1 &&
            src === sel, "resume");
        wdog = 1'b0;
    endtask
    task automatic t_halt;
        rq(3'h4);
        cy(2);
        chk(halted === 1'b1 && cpu === 1'b0 && per === 1'b0 &&
            irq === 1'b0, "halt");
        rq(3'h1);
        cy(3);
        chk(halted === 1'b1, "halt left");
        rst_n = 1'b0;
        cy(1);
        rst_n = 1'b1;
        cy(1);
        chk(halted === 1'b0 && mode === 3'h0 && cpu === 1'b1, "reset");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        t_run();
        t_slow();
        t_wfi();
        t_stop();
        t_halt();
        test_done();
    end
endmodule // test_power_mode_controller
`default_nettype wire
